// File: design/acm_pkg.sv
// acm_pkg: shared constants and types of the conversion-mode control block
// assumes: apb byte addressing, 32-bit data, one word per register
package acm_pkg;
   // register byte offsets
   localparam logic [11:0] ACM_REG_MODE_OFS = 12'h008;
   localparam logic [11:0] ACM_PRI_MODE_OFS = 12'h00c;
   localparam logic [11:0] ACM_STATUS_OFS = 12'h1f0;
   localparam logic [31:0] ACM_MODE_RESET = 32'h0000_0000;

   // regular mode register fields
   localparam int ACM_REG_SUB_LSB = 16;
   localparam int ACM_REG_SEQ_LSB = 8;
   localparam int ACM_ENABLE_BIT = 7;
   localparam int ACM_MODE_LSB = 0;
   localparam logic [31:0] ACM_REG_MODE_MASK = 32'h000f_0f83;
   // priority mode register fields
   localparam int ACM_PRI_SUB_LSB = 16;
   localparam int ACM_PRI_SEQ_LSB = 8;
   localparam logic [31:0] ACM_PRI_MODE_MASK = 32'h0003_0303;

   // status register fields
   localparam int ACM_ST_REG_BUSY = 0;
   localparam int ACM_ST_PRI_BUSY = 1;
   localparam int ACM_ST_CORE_BUSY = 2;
   localparam int ACM_ST_CORE_RST = 3;
   localparam int ACM_ST_REG_POS_LSB = 8;
   localparam int ACM_ST_PRI_POS_LSB = 16;

   // mode encodings
   localparam logic [1:0] ACM_MODE_ONESHOT = 2'h0;
   localparam logic [1:0] ACM_MODE_RESERVED = 2'h1;
   localparam logic [1:0] ACM_MODE_CONT = 2'h2;
   localparam logic [1:0] ACM_MODE_DISCONT = 2'h3;

   // converter clock as an enable: pclk divided by this count
   localparam int ACM_CONV_CLK_DIV = 4;
   localparam logic [3:0] ACM_CONV_DIV_LAST = 4'(ACM_CONV_CLK_DIV - 1);

   typedef struct packed {
      logic [1:0] mode;
      logic [3:0] seq_len;
      logic [3:0] sub_len;
   } acm_cfg_t;

   typedef struct packed {
      logic start;
      logic group_pri;
      logic [3:0] entry;
   } acm_conv_t;
endpackage

// File: design/acm_group_seq.sv
// acm_group_seq: walks one conversion group through its list entries
// assumes: grant and done pulses from the top arbiter, same clock
`timescale 1ns/10ps
module acm_group_seq
   import acm_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // configuration and control
   input wire acm_cfg_t cfg,
   input wire logic enable,
   input wire logic abort,
   input wire logic trig,
   // arbiter handshake
   input wire logic grant,
   input wire logic done,
   output logic req,
   output logic busy,
   output logic [3:0] pos
);
   typedef enum logic [1:0] {ACM_S_IDLE, ACM_S_ISSUE, ACM_S_WAIT} acm_seq_state_t;
   acm_seq_state_t state_r;
   logic [3:0] pos_r;
   logic [3:0] sub_cnt_r;
   logic last_seq;
   logic last_sub;

   assign last_seq = (pos_r == cfg.seq_len); // RULE7 RULE8
   assign last_sub = (sub_cnt_r == cfg.sub_len) || last_seq; // RULE4 RULE5 RULE6
   assign req = (state_r == ACM_S_ISSUE);
   assign busy = (state_r != ACM_S_IDLE);
   assign pos = pos_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ACM_S_IDLE;
         pos_r <= 4'h0;
         sub_cnt_r <= 4'h0;
      end else if (abort) begin
         state_r <= ACM_S_IDLE;
         pos_r <= 4'h0;
         sub_cnt_r <= 4'h0;
      end else begin
         unique case (state_r)
            ACM_S_IDLE: begin
               // reserved code ignores triggers: nothing defined to run
               if (trig && enable && cfg.mode != ACM_MODE_RESERVED) begin
                  state_r <= ACM_S_ISSUE;
               end
            end
            ACM_S_ISSUE: begin
               if (grant) begin
                  state_r <= ACM_S_WAIT;
               end
            end
            ACM_S_WAIT: begin
               if (done) begin
                  pos_r <= last_seq ? 4'h0 : pos_r + 4'h1;
                  unique case (cfg.mode)
                     ACM_MODE_CONT: begin
                        state_r <= ACM_S_ISSUE; // RULE11
                     end
                     ACM_MODE_DISCONT: begin
                        sub_cnt_r <= last_sub ? 4'h0 : sub_cnt_r + 4'h1; // RULE12
                        state_r <= last_sub ? ACM_S_IDLE : ACM_S_ISSUE; // RULE12
                     end
                     default: begin
                        state_r <= last_seq ? ACM_S_IDLE : ACM_S_ISSUE; // RULE10
                     end
                  endcase
               end
            end
         endcase
      end
   end
endmodule

// File: design/acm_top.sv
// acm_top: apb register file and sequencing for regular and priority conversion groups
// assumes: apb master on pclk; trigger and converter-core pulses come from logic on pclk
`timescale 1ns/10ps
//Contract
// RULE1 - regular mode change aborts regular, resets converter
// RULE2 - priority mode change aborts priority, resets converter
// RULE3 - software waits one converter clock after change
// RULE4 - regular subgroup holds field plus one
// RULE5 - priority subgroup holds field plus one
// RULE6 - final subgroup shortened to remaining channels
// RULE7 - regular sequence holds field plus one
// RULE8 - priority sequence holds field plus one
// RULE9 - bit seven enables the converter
// RULE10 - code 00 runs sequence once
// RULE11 - code 10 repeats sequence until changed
// RULE12 - code 11 runs one subgroup per trigger
// RULE13 - priority group has same mode codes
// RULE14 - software never programs reserved code 01
// RULE15 - software never programs channel codes above 0x11
module acm_top
   import acm_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // start triggers
   input wire logic regular_trig,
   input wire logic priority_trig,
   // converter core
   input wire logic conv_done,
   output logic conv_start,
   output logic conv_group_pri,
   output logic [3:0] conv_entry,
   output logic converter_enable,
   output logic converter_reset,
   output logic converter_clock_en
);
   logic [31:0] regular_mode_reg_r;
   logic [31:0] priority_mode_reg_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic setup_phase;
   logic wr_access;
   logic [31:0] reg_wr_val;
   logic [31:0] pri_wr_val;
   logic reg_change;
   logic pri_change;
   logic reg_abort_r;
   logic pri_abort_r;
   logic core_rst_r;
   logic [3:0] div_cnt_r;
   logic conv_clk_en_r;
   acm_cfg_t reg_cfg;
   acm_cfg_t pri_cfg;
   logic reg_req;
   logic pri_req;
   logic reg_busy;
   logic pri_busy;
   logic [3:0] reg_pos;
   logic [3:0] pri_pos;
   logic reg_grant;
   logic pri_grant;
   logic reg_done;
   logic pri_done;
   logic core_busy_r;
   logic owner_pri_r;
   acm_conv_t conv_r;
   logic [31:0] status_val;

   // ---------------- apb slave ----------------
   assign setup_phase = psel && !penable;
   assign wr_access = psel && penable && pready_r && pwrite;
   assign reg_wr_val = pwdata & ACM_REG_MODE_MASK;
   assign pri_wr_val = pwdata & ACM_PRI_MODE_MASK;
   // only a write that really alters the content counts as a change
   assign reg_change = wr_access && paddr == ACM_REG_MODE_OFS && reg_wr_val != regular_mode_reg_r;
   assign pri_change = wr_access && paddr == ACM_PRI_MODE_OFS && pri_wr_val != priority_mode_reg_r;

   always_comb begin
      status_val = 32'h0000_0000;
      status_val[ACM_ST_REG_BUSY] = reg_busy;
      status_val[ACM_ST_PRI_BUSY] = pri_busy;
      status_val[ACM_ST_CORE_BUSY] = core_busy_r;
      status_val[ACM_ST_CORE_RST] = core_rst_r;
      status_val[ACM_ST_REG_POS_LSB +: 4] = reg_pos;
      status_val[ACM_ST_PRI_POS_LSB +: 4] = pri_pos;
   end

   // answer is registered in the setup cycle, so every access ends in its first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup_phase;
         if (setup_phase) begin
            pslverr_r <= !(paddr == ACM_REG_MODE_OFS || paddr == ACM_PRI_MODE_OFS ||
                           (paddr == ACM_STATUS_OFS && !pwrite));
            unique case (paddr)
               ACM_REG_MODE_OFS: prdata_r <= pwrite ? 32'h0000_0000 : regular_mode_reg_r;
               ACM_PRI_MODE_OFS: prdata_r <= pwrite ? 32'h0000_0000 : priority_mode_reg_r;
               ACM_STATUS_OFS: prdata_r <= pwrite ? 32'h0000_0000 : status_val;
               default: prdata_r <= 32'h0000_0000;
            endcase
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // ---------------- mode registers ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regular_mode_reg_r <= ACM_MODE_RESET;
      end else if (reg_change) begin
         regular_mode_reg_r <= reg_wr_val;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         priority_mode_reg_r <= ACM_MODE_RESET;
      end else if (pri_change) begin
         priority_mode_reg_r <= pri_wr_val;
      end
   end

   assign reg_cfg.mode = regular_mode_reg_r[ACM_MODE_LSB +: 2];
   assign reg_cfg.seq_len = regular_mode_reg_r[ACM_REG_SEQ_LSB +: 4]; // RULE7
   assign reg_cfg.sub_len = regular_mode_reg_r[ACM_REG_SUB_LSB +: 4]; // RULE4
   assign pri_cfg.mode = priority_mode_reg_r[ACM_MODE_LSB +: 2]; // RULE13
   assign pri_cfg.seq_len = {2'h0, priority_mode_reg_r[ACM_PRI_SEQ_LSB +: 2]}; // RULE8
   assign pri_cfg.sub_len = {2'h0, priority_mode_reg_r[ACM_PRI_SUB_LSB +: 2]}; // RULE5

   // ---------------- abort and converter reset ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_abort_r <= 1'b0;
         pri_abort_r <= 1'b0;
      end else begin
         reg_abort_r <= reg_change; // RULE1
         pri_abort_r <= pri_change; // RULE2
      end
   end

   // converter clock stand-in: one-cycle enable every divider period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_r <= 4'h0;
         conv_clk_en_r <= 1'b0;
      end else begin
         div_cnt_r <= (div_cnt_r == ACM_CONV_DIV_LAST) ? 4'h0 : div_cnt_r + 4'h1;
         conv_clk_en_r <= (div_cnt_r == ACM_CONV_DIV_LAST);
      end
   end

   // reset stays up until a converter clock has passed, so the core sees it on its own edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_rst_r <= 1'b0;
      end else if (reg_change || pri_change) begin
         core_rst_r <= 1'b1; // RULE1 RULE2
      end else if (conv_clk_en_r) begin
         core_rst_r <= 1'b0; // RULE3
      end
   end

   assign converter_reset = core_rst_r;
   assign converter_clock_en = conv_clk_en_r;
   assign converter_enable = regular_mode_reg_r[ACM_ENABLE_BIT]; // RULE9

   // ---------------- group sequencers ----------------
   acm_group_seq u_reg_seq (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(reg_cfg),
      .enable(converter_enable),
      .abort(reg_abort_r),
      .trig(regular_trig),
      .grant(reg_grant),
      .done(reg_done),
      .req(reg_req),
      .busy(reg_busy),
      .pos(reg_pos)
   );

   acm_group_seq u_pri_seq (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(pri_cfg),
      .enable(converter_enable),
      .abort(pri_abort_r),
      .trig(priority_trig),
      .grant(pri_grant),
      .done(pri_done),
      .req(pri_req),
      .busy(pri_busy),
      .pos(pri_pos)
   );

   // ---------------- core arbiter ----------------
   // priority group wins a free core; it never preempts a running conversion
   assign pri_grant = !core_busy_r && !core_rst_r && pri_req;
   assign reg_grant = !core_busy_r && !core_rst_r && reg_req && !pri_req;
   assign reg_done = conv_done && core_busy_r && !owner_pri_r;
   assign pri_done = conv_done && core_busy_r && owner_pri_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_busy_r <= 1'b0;
         owner_pri_r <= 1'b0;
      end else if (reg_change || pri_change) begin
         core_busy_r <= 1'b0; // RULE1 RULE2
      end else if (pri_grant || reg_grant) begin
         core_busy_r <= 1'b1;
         owner_pri_r <= pri_grant;
      end else if (conv_done) begin
         core_busy_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_r <= '0;
      end else begin
         conv_r.start <= pri_grant || reg_grant;
         if (pri_grant || reg_grant) begin
            conv_r.group_pri <= pri_grant;
            conv_r.entry <= pri_grant ? pri_pos : reg_pos;
         end
      end
   end

   assign conv_start = conv_r.start;
   assign conv_group_pri = conv_r.group_pri;
   assign conv_entry = conv_r.entry;

   // ---------------- checks ----------------
   sequence s_reg_write;
      reg_change;
   endsequence

   sequence s_reg_abort_done;
      ##1 reg_abort_r ##1 !reg_busy;
   endsequence

   chk_reg_abort_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      s_reg_write |-> s_reg_abort_done)
      else $error("regular group still busy after mode change");

   chk_pri_abort_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      pri_change |-> ##2 !pri_busy && pri_pos == 4'h0)
      else $error("priority group still busy after mode change");

   sequence s_any_change;
      reg_change || pri_change;
   endsequence

   chk_core_rst_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE1 RULE2
      s_any_change |=> core_rst_r)
      else $error("converter reset not raised after mode change");

   chk_core_rst_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      core_rst_r && !conv_clk_en_r |=> core_rst_r)
      else $error("converter reset dropped before a converter clock");

   // a fresh change in the same cycle restarts the hold, so it is left out here
   chk_core_rst_drop: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      core_rst_r && conv_clk_en_r && !reg_change && !pri_change |=> !core_rst_r)
      else $error("converter reset held past its converter clock");

   chk_no_start_rst: assert property (@(posedge pclk) disable iff (!presetn) // RULE1 RULE2
      core_rst_r |=> !conv_start)
      else $error("conversion started while converter in reset");

   chk_enable_bit: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
      wr_access && paddr == ACM_REG_MODE_OFS |=> converter_enable == $past(pwdata[ACM_ENABLE_BIT]))
      else $error("converter enable does not follow bit seven");

   chk_oneshot_stop: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      reg_done && reg_cfg.mode == ACM_MODE_ONESHOT && reg_pos == reg_cfg.seq_len && !reg_abort_r
         |=> !reg_busy && reg_pos == 4'h0)
      else $error("one-shot sequence did not stop at its end");

   chk_cont_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
      reg_done && reg_cfg.mode == ACM_MODE_CONT && reg_pos == reg_cfg.seq_len && !reg_abort_r
         |=> reg_req && reg_pos == 4'h0)
      else $error("continuous sequence did not wrap");

   chk_discont_sub: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
      reg_done && reg_cfg.mode == ACM_MODE_DISCONT && reg_pos == reg_cfg.seq_len && !reg_abort_r
         |=> !reg_busy && reg_pos == 4'h0)
      else $error("discontinuous subgroup did not end at the sequence end");

   chk_seq_bound: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      conv_start && !conv_group_pri |-> conv_entry <= $past(reg_cfg.seq_len))
      else $error("regular entry beyond sequence length");

   chk_pri_bound: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      conv_start && conv_group_pri |-> conv_entry <= $past(pri_cfg.seq_len))
      else $error("priority entry beyond sequence length");

   chk_pri_discont: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      pri_done && pri_cfg.mode == ACM_MODE_DISCONT && pri_cfg.sub_len == 4'h0 && !pri_abort_r
         |=> !pri_busy)
      else $error("priority subgroup of one did not stop");

   chk_reg_sub_one: assert property (@(posedge pclk) disable iff (!presetn) // RULE4 RULE6
      reg_done && reg_cfg.mode == ACM_MODE_DISCONT && reg_cfg.sub_len == 4'h0 && !reg_abort_r
         |=> !reg_busy)
      else $error("regular subgroup of one did not stop");

   chk_pri_mode_same: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
      pri_done && pri_cfg.mode == ACM_MODE_CONT && pri_pos == pri_cfg.seq_len && !pri_abort_r
         |=> pri_req && pri_pos == 4'h0)
      else $error("priority continuous sequence did not wrap");

   chk_enable_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
      regular_trig && !converter_enable && !reg_busy |=> !reg_busy)
      else $error("trigger accepted while converter disabled");

   chk_clk_en_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      conv_clk_en_r |=> !conv_clk_en_r)
      else $error("converter clock enable wider than one cycle");

   chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("apb answer not ready in first access cycle");
endmodule

// File: sim/acm_core_model.sv
// acm_core_model: behavioural converter core on the far side of acm_top
// assumes: conv_start pulses on pclk; lat is driven by the bench
`timescale 1ns/10ps
module acm_core_model
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // conversion handshake
   input wire logic conv_start,
   input wire logic converter_reset,
   input wire logic [2:0] lat,
   output logic conv_done
);
   logic busy_r;
   logic [2:0] cnt_r;

   // a core in reset drops its conversion and never reports it done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'h0;
         cnt_r <= 3'h0;
         conv_done <= 1'h0;
      end else begin
         conv_done <= 1'h0;
         if (converter_reset) begin
            busy_r <= 1'h0;
         end else if (conv_start) begin
            busy_r <= 1'h1;
            cnt_r <= lat;
         end else if (busy_r && cnt_r == 3'h0) begin
            busy_r <= 1'h0;
            conv_done <= 1'h1;
         end else if (busy_r) begin
            cnt_r <= cnt_r - 3'h1;
         end
      end
   end
endmodule

// File: sim/tb_acm_top.sv
// tb_acm_top: self-checking bench for the conversion-mode control block
// assumes: acm_core_model answers conversions; this bench is the apb master
`timescale 1ns/10ps
module tb_acm_top
   import acm_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, regular_trig, priority_trig, err, pri;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, w;
   logic pready, pslverr, conv_done, conv_start, conv_group_pri;
   logic converter_enable, converter_reset, converter_clock_en;
   logic [3:0] conv_entry;
   logic [2:0] lat;
   logic [4:0] starts[$];
   int num_errors, num_checks, seed, i, l;

   acm_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .regular_trig, .priority_trig, .conv_done, .conv_start, .conv_group_pri, .conv_entry,
      .converter_enable, .converter_reset, .converter_clock_en);
   acm_core_model core_u (.pclk, .presetn, .conv_start, .converter_reset, .lat, .conv_done);

   initial begin
      pclk = 1'h0;
      forever #4 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (conv_start === 1'h1) begin
         // entries map one to one onto input codes 0x0..0xf, so invalid codes never reach the core
         starts.push_back({conv_group_pri, conv_entry});
      end
   end

   task automatic wrap_up();
      if (num_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic give_up();
      num_errors++;
      wrap_up();
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [31:0] mode_word(logic [1:0] m, int l, int s, bit en);
      return (32'(s) << 16) | (32'(l) << 8) | (32'(en) << 7) | 32'(m);
   endfunction

   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'h1) break;
      end
      if (k == 20) give_up();
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // two converter clock ticks give margin over the single tick software must leave
   task automatic wait_cc();
      int k, seen, gap;
      seen = 0;
      gap = 0;
      for (k = 0; k < 40 && seen < 2; k++) begin
         @(posedge pclk);
         gap++;
         if (converter_clock_en === 1'h1) begin
            if (seen == 1) check("conv_clk_period", gap, ACM_CONV_CLK_DIV);
            seen++;
            gap = 0;
         end
      end
      if (seen < 2) give_up();
      @(posedge pclk);
   endtask

   task automatic wr_cfg(input bit p, input logic [31:0] v);
      apb(1'h1, p ? ACM_PRI_MODE_OFS : ACM_REG_MODE_OFS, v);
      wait_cc();
   endtask

   task automatic fire(input bit p);
      #1 starts.delete();
      @(posedge pclk);
      lat <= 3'($urandom_range(0, 5));
      regular_trig <= !p;
      priority_trig <= p;
      @(posedge pclk);
      regular_trig <= 1'h0;
      priority_trig <= 1'h0;
   endtask

   task automatic burst(input bit p, input int n, input int first);
      int k;
      fire(p);
      for (k = 0; k < 600 && starts.size() < n; k++) @(posedge pclk);
      if (k == 600) give_up();
      repeat (40) @(posedge pclk);
      check("start_count", starts.size(), n);
      for (k = 0; k < n; k++) check("entry", starts[k], {p, 4'(first + k)});
   endtask

   task automatic disc_run(input bit p, input int l, input int s);
      int pos, cnt, b;
      pos = 0;
      wr_cfg(p, mode_word(ACM_MODE_DISCONT, l, s, !p));
      for (b = 0; b < (l + 1 + s) / (s + 1) + 1; b++) begin
         cnt = (s < l - pos) ? s + 1 : l + 1 - pos;
         burst(p, cnt, pos);
         pos = (pos + cnt > l) ? 0 : pos + cnt;
      end
   endtask

   task automatic cont_abort(input bit p, input int l);
      int k;
      wr_cfg(p, mode_word(ACM_MODE_CONT, l, 0, !p));
      fire(p);
      for (k = 0; k < 1000 && starts.size() < 3 * (l + 1); k++) @(posedge pclk);
      if (k == 1000) give_up();
      for (k = 0; k < 3 * (l + 1); k++) check("cont_entry", starts[k], {p, 4'(k % (l + 1))});
      apb(1'h1, p ? ACM_PRI_MODE_OFS : ACM_REG_MODE_OFS, mode_word(ACM_MODE_ONESHOT, l, 0, !p));
      for (k = 0; k < 6 && converter_reset !== 1'h1; k++) @(posedge pclk);
      check("reset_on_change", converter_reset, 1'h1);
      wait_cc();
      #1 starts.delete();
      repeat (40) @(posedge pclk);
      check("starts_after_abort", starts.size(), 0);
   endtask

   initial begin
      seed = $urandom(21);
      {psel, penable, pwrite, regular_trig, priority_trig, presetn} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      lat = 3'h1;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, ACM_REG_MODE_OFS, 32'h0);
      check("reg_reset", rd, 32'h0);
      apb(1'h0, ACM_PRI_MODE_OFS, 32'h0);
      check("pri_reset", rd, 32'h0);
      apb(1'h0, 12'h040, 32'h0);
      check("unmapped_err", err, 1'h1);
      check("unmapped_rd", rd, 32'h0);
      apb(1'h0, ACM_STATUS_OFS, 32'h0);
      check("status_idle", rd, 32'h0);
      check("status_err", err, 1'h0);
      apb(1'h1, ACM_STATUS_OFS, 32'hffff_ffff);
      check("status_write_err", err, 1'h1);
      for (i = 0; i < 8; i++) begin
         pri = i[0];
         w = $urandom();
         w[1:0] = (w[1:0] == 2'h1) ? 2'h3 : w[1:0];
         wr_cfg(pri, w);
         apb(1'h0, pri ? ACM_PRI_MODE_OFS : ACM_REG_MODE_OFS, 32'h0);
         check("readback", rd, w & (pri ? 32'h0003_0303 : 32'h000f_0f83));
         if (!pri) check("enable_out", converter_enable, w[7]);
      end
      wr_cfg(1'h0, mode_word(ACM_MODE_ONESHOT, 3, 0, 0));
      burst(1'h0, 0, 0);
      for (i = 0; i < 4; i++) begin
         l = (i == 0) ? 0 : (i == 1) ? 15 : $urandom_range(1, 14);
         wr_cfg(1'h0, mode_word(ACM_MODE_ONESHOT, l, $urandom_range(0, 15), 1));
         burst(1'h0, l + 1, 0);
      end
      disc_run(1'h0, 6, 2);
      disc_run(1'h0, $urandom_range(7, 15), $urandom_range(0, 15));
      disc_run(1'h0, $urandom_range(1, 6), 0);
      wr_cfg(1'h0, mode_word(ACM_MODE_ONESHOT, 0, 0, 1));
      for (i = 0; i < 4; i++) begin
         wr_cfg(1'h1, mode_word(ACM_MODE_ONESHOT, i, 3, 0));
         burst(1'h1, i + 1, 0);
      end
      disc_run(1'h1, 2, 1);
      disc_run(1'h1, 3, 0);
      cont_abort(1'h0, $urandom_range(0, 15));
      cont_abort(1'h1, 1);
      wrap_up();
   end
endmodule
